// ---- core/flash_cfg_pkg.sv ----
// Purpose: shared constants and types for the flash configuration register bank
// Assumes: serial command opcodes are local choices
// Notes:   field positions index the persistent (16-bit) and temporary (8-bit) words
package flash_cfg_pkg;

  localparam int          PERS_W         = 16;
  localparam int          TEMP_W         = 8;
  localparam int          CMD_W          = 8;
  localparam int          CNT_W          = 5;

  localparam logic [15:0] PERS_RESET     = 16'hffff;
  localparam logic [7:0]  TEMP_RESET     = 8'hfb;

  localparam int          P_DUMMY_HI     = 15;
  localparam int          P_DUMMY_LO     = 12;
  localparam int          P_XIP_HI       = 11;
  localparam int          P_XIP_LO       = 9;
  localparam int          P_DTR          = 5;
  localparam int          P_DQ3          = 4;
  localparam int          P_QUAD         = 3;
  localparam int          P_DUAL         = 2;
  localparam int          P_SEG          = 1;
  localparam int          P_ADDR         = 0;
  localparam int          T_DUMMY_HI     = 7;
  localparam int          T_DUMMY_LO     = 4;
  localparam int          T_XIP          = 3;
  localparam int          T_RSVD         = 2;
  localparam int          T_WRAP_HI      = 1;
  localparam int          T_WRAP_LO      = 0;

  localparam logic [3:0]  DUMMY_ALIAS    = 4'h0;
  localparam logic [3:0]  DUMMY_DFLT_CODE = 4'hf;

  localparam logic [2:0]  XIP_DISABLED   = 3'h7;
  localparam logic [2:0]  XIP_RSVD_A     = 3'h5;
  localparam logic [2:0]  XIP_RSVD_B     = 3'h6;

  localparam logic [2:0]  SEG_LOWEST     = 3'h0;
  localparam logic [2:0]  SEG_HIGHEST    = 3'h7;

  localparam logic [6:0]  WRAP16_MASK    = 7'h0f;
  localparam logic [6:0]  WRAP32_MASK    = 7'h1f;
  localparam logic [6:0]  WRAP64_MASK    = 7'h3f;

  // opcodes are arbitrary values
  localparam logic [7:0]  CMD_RD_PERS    = 8'h11;
  localparam logic [7:0]  CMD_WR_PERS    = 8'h12;
  localparam logic [7:0]  CMD_RD_TEMP    = 8'h21;
  localparam logic [7:0]  CMD_WR_TEMP    = 8'h22;

  localparam logic [4:0]  CMD_LAST_BIT   = 5'h07;
  localparam logic [4:0]  DATA_FIRST_BIT = 5'h08;
  localparam logic [4:0]  TEMP_LAST_BIT  = 5'h0f;
  localparam logic [4:0]  PERS_LAST_BIT  = 5'h17;
  localparam logic [4:0]  CNT_MAX        = 5'h1f;

  typedef enum logic [1:0] {
    WRAP_16   = 2'b00,
    WRAP_32   = 2'b01,
    WRAP_64   = 2'b10,
    WRAP_CONT = 2'b11
  } wrap_t;

  typedef enum logic [1:0] {
    PROTO_SINGLE = 2'b00,
    PROTO_DUAL   = 2'b01,
    PROTO_QUAD   = 2'b10
  } protocol_t;

endpackage : flash_cfg_pkg

// ---- core/flash_config_registers.sv ----
// Purpose: persistent and temporary configuration registers with working configuration
// Assumes: serial link mode 0, msb first; link clock stops outside frames
// Notes:   registers live on ref_clk_i; the link side captures words and raises a toggle
`timescale 1ns/1ps
module flash_config_registers
  import flash_cfg_pkg::*;
#(
  parameter logic [3:0] DUMMY_DEFAULT = 4'h8,
  parameter int         ADDR_W        = 27
) (
  input  wire logic              ref_clk_i,
  input  wire logic              rst_b_i,
  input  wire logic              sclk_i,
  input  wire logic              cs_b_i,
  input  wire logic              dq0_i,
  output logic                   dq1_o,
  output logic                   dq1_oe_o,
  input  wire logic              dq3_i,
  input  wire logic              addr_load_i,
  input  wire logic [31:0]       addr_in_i,
  input  wire logic              addr_step_i,
  output logic [ADDR_W-1:0]      addr_o,
  output logic [3:0]             dummy_cycles_o,
  output logic                   xip_active_o,
  output logic [2:0]             xip_type_o,
  output logic                   dtr_mode_o,
  output logic                   dq3_func_en_o,
  output protocol_t              protocol_o,
  output logic                   addr_4byte_o,
  output logic [2:0]             segment_o,
  output wrap_t                  wrap_o
);

  function automatic logic [3:0] dummy_count(input logic [3:0] code);
    dummy_count = (code == DUMMY_ALIAS || code == DUMMY_DFLT_CODE) ? DUMMY_DEFAULT : code;
  endfunction : dummy_count

  function automatic logic [ADDR_W-1:0] step_addr(input logic [ADDR_W-1:0] a,
                                                  input wrap_t w);
    logic [ADDR_W-1:0] mask;
    mask = '1;
    unique case (w)
      WRAP_16:   mask = {{(ADDR_W-7){1'b0}}, WRAP16_MASK};
      WRAP_32:   mask = {{(ADDR_W-7){1'b0}}, WRAP32_MASK};
      WRAP_64:   mask = {{(ADDR_W-7){1'b0}}, WRAP64_MASK};
      WRAP_CONT: mask = '1;
    endcase
    step_addr = (a & ~mask) | ((a + 1'b1) & mask);
  endfunction : step_addr

  // ---------------- link domain ----------------
  logic [CNT_W-1:0]  bit_cnt;
  logic [PERS_W-1:0] shift_in;
  logic [CMD_W-1:0]  cmd;
  logic [PERS_W-1:0] wr_data;
  logic              wr_is_temp;
  logic              wr_tog;
  logic [23:0]       rd_meta;
  logic [23:0]       rd_sync;
  logic [PERS_W-1:0] persistent = PERS_RESET;
  logic [TEMP_W-1:0] temporary;

  wire logic [PERS_W-1:0] next_shift   = {shift_in[PERS_W-2:0], dq0_i};
  wire logic              cmd_done     = (bit_cnt == CMD_LAST_BIT);
  wire logic              pers_wr_done = (cmd == CMD_WR_PERS) && (bit_cnt == PERS_LAST_BIT);
  wire logic              temp_wr_done = (cmd == CMD_WR_TEMP) && (bit_cnt == TEMP_LAST_BIT);
  wire logic              rd_pers      = (cmd == CMD_RD_PERS);
  wire logic              rd_temp      = (cmd == CMD_RD_TEMP);
  wire logic              in_data      = (bit_cnt >= DATA_FIRST_BIT);
  wire logic [CNT_W-1:0]  rd_idx       = bit_cnt - DATA_FIRST_BIT;
  wire logic              rd_pers_bit  = (rd_idx < CNT_W'(PERS_W)) ?
                                         rd_sync[23 - rd_idx] : 1'b0;
  wire logic              rd_temp_bit  = (rd_idx < CNT_W'(TEMP_W)) ?
                                         rd_sync[7 - rd_idx] : 1'b0;
  wire logic              next_dq1     = rd_pers ? rd_pers_bit : rd_temp_bit;
  wire logic              next_oe      = (rd_pers || rd_temp) && in_data;

  // frame counters restart whenever chip select rises
  always_ff @(posedge sclk_i or negedge rst_b_i or posedge cs_b_i) begin
    if (!rst_b_i || cs_b_i) begin
      bit_cnt  <= '0;
      shift_in <= '0;
      cmd      <= '0;
    end else begin
      bit_cnt  <= (bit_cnt == CNT_MAX) ? bit_cnt : bit_cnt + 1'b1;
      shift_in <= next_shift;
      if (cmd_done) begin
        cmd <= next_shift[CMD_W-1:0];
      end
    end
  end

  // captured word stays stable until the next write completes
  always_ff @(posedge sclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_data    <= '0;
      wr_is_temp <= 1'b0;
      wr_tog     <= 1'b0;
    end else if (pers_wr_done) begin
      wr_data    <= next_shift;
      wr_is_temp <= 1'b0;
      wr_tog     <= ~wr_tog;
    end else if (temp_wr_done) begin
      wr_data    <= {{(PERS_W-TEMP_W){1'b0}}, next_shift[TEMP_W-1:0]};
      wr_is_temp <= 1'b1;
      wr_tog     <= ~wr_tog;
    end
  end

  // quasi-static register copies for read-back
  always_ff @(posedge sclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_meta <= '0;
      rd_sync <= '0;
    end else begin
      rd_meta <= {persistent, temporary};
      rd_sync <= rd_meta;
    end
  end

  // read data launched on the falling edge for a rising-edge host
  always_ff @(negedge sclk_i or negedge rst_b_i or posedge cs_b_i) begin
    if (!rst_b_i || cs_b_i) begin
      dq1_o    <= 1'b0;
      dq1_oe_o <= 1'b0;
    end else begin
      dq1_o    <= next_dq1;
      dq1_oe_o <= next_oe;
    end
  end

  // ---------------- reference domain ----------------
  logic [2:0]        tog_sync;
  logic [1:0]        dq3_sync;
  logic              load_pending;
  logic [5:0]        wk_static;
  logic [2:0]        wk_xip_type;
  logic [2:0]        segment;
  logic [ADDR_W-1:0] addr;

  wire logic       wr_evt      = tog_sync[2] ^ tog_sync[1];
  wire logic       func_reset  = ~dq3_sync[1] & wk_static[P_DQ3];
  wire logic [2:0] p_xip       = persistent[P_XIP_HI:P_XIP_LO];
  wire logic       p_xip_off   = (p_xip == XIP_DISABLED) || (p_xip == XIP_RSVD_A) ||
                                 (p_xip == XIP_RSVD_B);
  wire logic [7:0] temp_load   = {persistent[P_DUMMY_HI:P_DUMMY_LO], p_xip_off,
                                  1'b0, WRAP_CONT};
  wire logic [7:0] temp_write  = {wr_data[T_DUMMY_HI:T_WRAP_HI+1] & 6'h3e,
                                  wr_data[T_WRAP_HI:T_WRAP_LO]};
  wire logic [2:0] seg_load    = persistent[P_SEG] ? SEG_LOWEST : SEG_HIGHEST;
  wire logic [ADDR_W-1:0] addr_formed = wk_static[P_ADDR] ?
                                 {segment, addr_in_i[23:0]} :
                                 addr_in_i[ADDR_W-1:0];
  wire wrap_t      next_wrap   = wrap_t'(temporary[T_WRAP_HI:T_WRAP_LO]);
  wire protocol_t  next_proto  = !wk_static[P_QUAD] ? PROTO_QUAD :
                                 !wk_static[P_DUAL] ? PROTO_DUAL : PROTO_SINGLE;

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tog_sync <= '0;
      dq3_sync <= 2'b11;
    end else begin
      tog_sync <= {tog_sync[1:0], wr_tog};
      dq3_sync <= {dq3_sync[0], dq3_i};
    end
  end

  // nonvolatile word: comes up erased and keeps its value through every reset
  always_ff @(posedge ref_clk_i) begin
    if (wr_evt && !wr_is_temp) begin
      persistent <= wr_data;
    end
  end

  // reload request: set by reset release or the pin reset, wins over a temporary write
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      load_pending <= 1'b1;
    end else begin
      load_pending <= func_reset;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      temporary   <= TEMP_RESET;
      wk_static   <= PERS_RESET[5:0];
      wk_xip_type <= XIP_DISABLED;
      segment     <= SEG_LOWEST;
    end else if (load_pending) begin
      temporary   <= temp_load;
      wk_static   <= persistent[5:0];
      wk_xip_type <= p_xip_off ? XIP_DISABLED : p_xip;
      segment     <= seg_load;
    end else if (wr_evt && wr_is_temp) begin
      temporary   <= temp_write;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      addr <= '0;
    end else if (addr_load_i) begin
      addr <= addr_formed;
    end else if (addr_step_i) begin
      addr <= step_addr(addr, next_wrap);
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      dummy_cycles_o <= DUMMY_DEFAULT;
      xip_active_o   <= 1'b0;
      xip_type_o     <= XIP_DISABLED;
      dtr_mode_o     <= 1'b0;
      dq3_func_en_o  <= 1'b1;
      protocol_o     <= PROTO_SINGLE;
      addr_4byte_o   <= 1'b0;
      segment_o      <= SEG_LOWEST;
      wrap_o         <= WRAP_CONT;
    end else begin
      dummy_cycles_o <= dummy_count(temporary[T_DUMMY_HI:T_DUMMY_LO]);
      xip_active_o   <= ~temporary[T_XIP];
      xip_type_o     <= wk_xip_type;
      dtr_mode_o     <= ~wk_static[P_DTR];
      dq3_func_en_o  <= wk_static[P_DQ3];
      protocol_o     <= next_proto;
      addr_4byte_o   <= ~wk_static[P_ADDR];
      segment_o      <= segment;
      wrap_o         <= next_wrap;
    end
  end

  assign addr_o = addr;

  // ---------------- checks ----------------
  a_load_dummy: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    load_pending |=> temporary[T_DUMMY_HI:T_DUMMY_LO] == $past(persistent[P_DUMMY_HI:P_DUMMY_LO]))
    else $error("dummy field not loaded from persistent word");

  a_xip_reserved: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    load_pending && (p_xip == XIP_RSVD_A || p_xip == XIP_RSVD_B) |=> ##1 !xip_active_o)
    else $error("reserved xip code left xip active");

  a_pers_write: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    wr_evt && !wr_is_temp |=> persistent == $past(wr_data))
    else $error("persistent write lost");

  a_temp_apply: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    wr_evt && wr_is_temp && !load_pending |=> ##1
      dummy_cycles_o == dummy_count($past(wr_data[T_DUMMY_HI:T_DUMMY_LO], 2)))
    else $error("temporary write not applied");

  a_dummy_alias: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    temporary[T_DUMMY_HI:T_DUMMY_LO] == DUMMY_ALIAS |=> dummy_cycles_o == DUMMY_DEFAULT)
    else $error("dummy code zero not treated as default");

  a_quad_wins: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    !wk_static[P_QUAD] && !wk_static[P_DUAL] |=> protocol_o == PROTO_QUAD)
    else $error("dual protocol chosen over quad");

  a_wrap_block: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    addr_step_i && !addr_load_i && next_wrap == WRAP_16 |=>
      addr[ADDR_W-1:4] == $past(addr[ADDR_W-1:4]))
    else $error("wrapped read left its block");

  a_addr_4byte: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    addr_load_i && !wk_static[P_ADDR] |=> addr == $past(addr_in_i[ADDR_W-1:0]))
    else $error("segment used in four-byte mode");

  a_seg_reset: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    load_pending && !persistent[P_SEG] |=> ##1 segment_o == SEG_HIGHEST)
    else $error("segment not set highest");

  a_oe_idle: assert property (
    @(posedge sclk_i) disable iff (!rst_b_i)
    !(rd_pers || rd_temp) |-> !dq1_oe_o)
    else $error("data line driven outside a read");

  a_dummy_literal: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    load_pending && persistent[P_DUMMY_HI:P_DUMMY_LO] != DUMMY_ALIAS &&
      persistent[P_DUMMY_HI:P_DUMMY_LO] != DUMMY_DFLT_CODE |=> ##1
      dummy_cycles_o == $past(persistent[P_DUMMY_HI:P_DUMMY_LO], 2))
    else $error("literal dummy code not applied");

  a_xip_type: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    load_pending && !p_xip_off |=> ##1 xip_type_o == $past(p_xip, 2))
    else $error("power-on xip type not applied");

  a_dtr_load: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    load_pending |=> ##1 dtr_mode_o == !$past(persistent[P_DTR], 2))
    else $error("double-rate mode not taken from persistent word");

  a_pin_ignored: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    !wk_static[P_DQ3] |=> !load_pending)
    else $error("data line three reset acted while disabled");

  a_addr_3byte: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    addr_load_i && wk_static[P_ADDR] |=> addr == {$past(segment), $past(addr_in_i[23:0])})
    else $error("three-byte address lost its segment");

  c_temp_write: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    wr_evt && wr_is_temp);
  c_pers_write: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    wr_evt && !wr_is_temp);
  c_pin_reset: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    func_reset);
  c_wrap_round: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    addr_step_i && next_wrap != WRAP_CONT ##1 addr[3:0] == 4'h0);

endmodule : flash_config_registers

// ---- test/spi_host_model.sv ----
// Purpose: serial host that issues configuration command frames
// Assumes: mode 0, msb first; link clock idles low between frames
// Notes:   160 ns link period; a released data line shows the inverse of its last bit
`timescale 1ns/1ps
module spi_host_model (
  output logic      sclk_o,
  output logic      cs_b_o,
  output logic      dq0_o,
  input  wire logic dq1_i
);
  initial begin
    sclk_o = 1'b0;
    cs_b_o = 1'b1;
    dq0_o  = 1'b0;
  end

  // opcode then nbits of data; answer bits are taken on rising edges
  task automatic frame(input logic [7:0] op, input logic [15:0] wdata, input int nbits,
                       output logic [15:0] rdata);
    logic [23:0] word;
    word  = {op, wdata << (16 - nbits)};
    rdata = '0;
    #23;
    cs_b_o = 1'b0;
    for (int i = 0; i < 8 + nbits; i++) begin
      dq0_o = word[23 - i];
      #80 sclk_o = 1'b1;
      if (i >= 8) begin
        rdata = {rdata[14:0], dq1_i};
      end
      #80 sclk_o = 1'b0;
    end
    #80 cs_b_o = 1'b1;
    dq0_o = ~dq0_o;
  endtask : frame
endmodule : spi_host_model

// ---- test/flash_config_registers_bench.sv ----
// Purpose: self-checking bench for the configuration register bank
// Assumes: host model drives the link; ref clock 100 ns
// Notes:   expectations are decoded here from the field definitions
`timescale 1ns/1ps
module flash_config_registers_bench;
  import flash_cfg_pkg::*;
  localparam logic [3:0] DFLT = 4'h8;
  logic        ref_clk_i;
  logic        rst_b_i;
  logic        dq3_i;
  logic        addr_load_i;
  logic        addr_step_i;
  logic [31:0] addr_in_i;
  logic        sclk;
  logic        cs_b;
  logic        dq0;
  logic        dq1;
  logic        dq1_oe;
  logic [26:0] addr;
  logic [3:0]  dummy;
  logic        xip_active;
  logic [2:0]  xtype;
  logic        dtr;
  logic        dq3en;
  protocol_t   proto;
  logic        a4;
  logic [2:0]  seg;
  wrap_t       wrap;
  logic [14:0] cfg;
  int          failures;
  int          compares;
  int          cycles;
  logic [3:0]  codes [4] = '{4'h0, 4'h1, 4'he, 4'hf};
  logic [15:0] pv [4]    = '{16'h3000, 16'h0bf9, 16'h18ee, 16'hedf7};
  logic [26:0] wexp [4]  = '{27'h31, 27'h21, 27'h01, 27'h41};

  assign cfg = {dummy, xtype, dtr, dq3en, proto, seg, a4};

  flash_config_registers #(.DUMMY_DEFAULT(DFLT)) flash_config_registers_i (
    .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .sclk_i(sclk), .cs_b_i(cs_b), .dq0_i(dq0),
    .dq1_o(dq1), .dq1_oe_o(dq1_oe), .dq3_i(dq3_i), .addr_load_i(addr_load_i),
    .addr_in_i(addr_in_i), .addr_step_i(addr_step_i), .addr_o(addr),
    .dummy_cycles_o(dummy), .xip_active_o(xip_active), .xip_type_o(xtype),
    .dtr_mode_o(dtr), .dq3_func_en_o(dq3en), .protocol_o(proto),
    .addr_4byte_o(a4), .segment_o(seg), .wrap_o(wrap));

  spi_host_model spi_host_model_i (.sclk_o(sclk), .cs_b_o(cs_b), .dq0_o(dq0), .dq1_i(dq1));

  initial begin
    ref_clk_i = 1'b0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end

  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      $display("[ERR] run expected done seen hang");
      end_sim();
    end
  end

  function automatic logic [3:0] dec(input logic [3:0] c);
    return (c == 4'h0 || c == 4'hf) ? DFLT : c;
  endfunction : dec

  function automatic logic [14:0] exp_cfg(input logic [15:0] p);
    logic [2:0] x;
    logic [1:0] pr;
    x  = (p[11:9] == 3'h5 || p[11:9] == 3'h6) ? 3'h7 : p[11:9];
    pr = !p[3] ? 2'b10 : (!p[2] ? 2'b01 : 2'b00);
    return {dec(p[15:12]), x, ~p[5], p[4], pr, p[1] ? 3'h0 : 3'h7, ~p[0]};
  endfunction : exp_cfg

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask : cyc

  task automatic rst();
    rst_b_i = 1'b0;
    cyc(6);
    rst_b_i = 1'b1;
    cyc(3);
  endtask : rst

  task automatic wr(input logic [7:0] op, input logic [15:0] d, input int nb);
    logic [15:0] r;
    spi_host_model_i.frame(op, d, nb, r);
    cyc(10);
  endtask : wr

  task automatic rd(input logic [7:0] op, input int nb, input logic [15:0] exp, input string nm);
    logic [15:0] r;
    spi_host_model_i.frame(op, 16'h0, nb, r);
    chk(nm, exp, r);
    cyc(2);
    chk("dq1_oe", 0, dq1_oe);
  endtask : rd

  task automatic addr_chk(input logic [31:0] a, input int n, input logic [26:0] e);
    addr_in_i   = a;
    addr_load_i = 1'b1;
    cyc(1);
    addr_load_i = 1'b0;
    addr_step_i = (n > 0);
    cyc(n);
    addr_step_i = 1'b0;
    cyc(1);
    chk("addr", e, addr);
  endtask : addr_chk

  task automatic end_sim();
    $display("counts: compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_sim

  initial begin
    logic [7:0]  t;
    failures = 0;
    compares = 0;
    cycles = 0;
    rst_b_i = 1'b0;
    dq3_i = 1'b1;
    addr_load_i = 1'b0;
    addr_step_i = 1'b0;
    addr_in_i = 32'h0;
    rst();
    chk("cfg", exp_cfg(16'hffff), cfg);
    chk("xip_active", 0, xip_active);
    chk("wrap", 3, wrap);
    rd(CMD_RD_PERS, 16, 16'hffff, "pers");
    rd(CMD_RD_TEMP, 8, 16'h00fb, "temp");
    $display("test defaults done");
    // dummy count must suit the host clock, so codes 0, 1, e and f are applied and read back
    for (int i = 0; i < 4; i++) begin
      t = {codes[i], i[0], 1'b1, i[1:0]};
      wr(CMD_WR_TEMP, {8'h0, t}, 8);
      chk("dummy", dec(codes[i]), dummy);
      chk("xip_active", !i[0], xip_active);
      chk("wrap", i[1:0], wrap);
      rd(CMD_RD_TEMP, 8, {8'h0, t & 8'hfb}, "temp");
      addr_chk(32'h3e, 3, wexp[i]);
    end
    $display("test temporary done");
    for (int i = 0; i < 4; i++) begin
      wr(CMD_WR_PERS, pv[i], 16);
      rst();
      chk("cfg", exp_cfg(pv[i]), cfg);
      chk("cfg", exp_cfg(pv[i]), cfg);
      rd(CMD_RD_PERS, 16, pv[i], "pers");
      addr_chk(32'h0512345e, 0, pv[i][0] ? {pv[i][1] ? 3'h0 : 3'h7, 24'h12345e}
                                         : 27'h512345e);
      wr(CMD_WR_TEMP, 16'h002b, 8);
      dq3_i = 1'b0;
      cyc(4);
      dq3_i = 1'b1;
      cyc(4);
      chk("dummy", pv[i][4] ? dec(pv[i][15:12]) : 4'h2, dummy);
    end
    $display("test persistent done");
    end_sim();
  end
endmodule : flash_config_registers_bench
